// *** rtl/acalu_alu.sv ***
// Combinational arithmetic and bit unit of the accumulator ALU block.
// Assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/1ps
module acalu_alu (
    input wire acalu_pkg::acalu_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_idx,
    output logic [7:0] result,
    output logic carry,
    output logic digit_carry,
    output logic zero,
    output logic bit_val
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] mask;

    always_comb begin
        sum = {1'b0, acc} + {1'b0, operand};
        nib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
        mask = 8'h01 << bit_idx;
        unique case (op)
            acalu_pkg::ACALU_ADD_LITERAL_TO_ACC,
            acalu_pkg::ACALU_ADD_ACC_AND_REG: result = sum[7:0];
            acalu_pkg::ACALU_AND_ACC_WITH_REG,
            acalu_pkg::ACALU_AND_LITERAL_WITH_ACC: result = acc & operand;
            acalu_pkg::ACALU_BIT_CLEAR_OP: result = operand & ~mask;
            acalu_pkg::ACALU_BIT_SET_OP: result = operand | mask;
            acalu_pkg::ACALU_REGISTER_CLEAR_OP: result = 8'h00;
            default: result = operand;
        endcase
        carry = sum[8];
        digit_carry = nib[4];
        zero = (result == 8'h00);
        bit_val = operand[bit_idx];
    end
endmodule

// *** rtl/acalu_file_regs.sv ***
// File-register array: one synchronous write port, one combinational read port.
// Assumes a single writer per cycle, arbitrated by the parent.
`timescale 1ns/1ps
module acalu_file_regs #(
    parameter int unsigned AW = 7,
    parameter int unsigned DW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= DW'(acalu_pkg::ACALU_FILE_RST);
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_q[rd_addr];
endmodule

// *** rtl/acalu_pkg.sv ***
// Shared constants for the accumulator ALU block: register map, field layout, reset values, operation codes.
// Assumes a 32-bit APB bus with word-aligned registers.
package acalu_pkg;

    // Byte offsets of the APB registers.
    localparam logic [11:0] ACALU_OFF_INSTR = 12'h000;
    localparam logic [11:0] ACALU_OFF_ACC = 12'h004;
    localparam logic [11:0] ACALU_OFF_STATUS = 12'h008;
    localparam logic [11:0] ACALU_OFF_FADDR = 12'h00C;
    localparam logic [11:0] ACALU_OFF_FDATA = 12'h010;
    localparam logic [11:0] ACALU_OFF_CFG = 12'h014;
    localparam logic [11:0] ACALU_OFF_CYCLES = 12'h018;

    // Fields of the instruction word.
    localparam int unsigned ACALU_OP_LSB = 0;
    localparam int unsigned ACALU_DEST_POS = 4;
    localparam int unsigned ACALU_BIT_LSB = 5;
    localparam int unsigned ACALU_FA_LSB = 8;
    localparam int unsigned ACALU_LIT_LSB = 16;

    // Status bit positions.
    localparam int unsigned ACALU_ST_C = 0;
    localparam int unsigned ACALU_ST_DIGIT_CARRY = 1;
    localparam int unsigned ACALU_ST_Z = 2;
    localparam int unsigned ACALU_ST_SKIP = 3;

    // Values after reset.
    localparam logic [7:0] ACALU_ACC_RST = 8'h00;
    localparam logic [7:0] ACALU_FILE_RST = 8'h00;
    localparam logic [2:0] ACALU_FLAGS_RST = 3'h0;
    localparam logic ACALU_CFG_RST = 1'b0;

    // Default file addresses of the timer-zero and I/O port registers.
    localparam logic [6:0] ACALU_TIMER_ZERO_ADDR = 7'h01;
    localparam logic [6:0] ACALU_PORT_ADDR = 7'h06;

    typedef enum logic [3:0] {
        ACALU_NOP = 4'h0,
        ACALU_ADD_LITERAL_TO_ACC = 4'h1,
        ACALU_ADD_ACC_AND_REG = 4'h2,
        ACALU_AND_ACC_WITH_REG = 4'h3,
        ACALU_AND_LITERAL_WITH_ACC = 4'h4,
        ACALU_BIT_CLEAR_OP = 4'h5,
        ACALU_BIT_SET_OP = 4'h6,
        ACALU_SKIP_IF_BIT_SET = 4'h7,
        ACALU_SKIP_IF_BIT_CLEAR = 4'h8,
        ACALU_REGISTER_CLEAR_OP = 4'h9
    } acalu_op_t;

endpackage

// *** rtl/acalu_top.sv ***
// Accumulator ALU datapath with APB register access, bit operations and skip tests.
// Assumes one APB master; pins on port_pins are asynchronous to pclk.
`timescale 1ns/1ps
module acalu_top #(
    parameter int unsigned AW = 12,
    parameter int unsigned CYC_W = 16,
    parameter logic [6:0] TIMER_ZERO_ADDR = acalu_pkg::ACALU_TIMER_ZERO_ADDR,
    parameter logic [6:0] PORT_ADDR = acalu_pkg::ACALU_PORT_ADDR
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_latch,
    output logic [7:0] acc,
    output logic flag_c,
    output logic digit_carry_flag,
    output logic flag_z,
    output logic skip_next,
    output logic prescaler_clear
);
    // Offsets that answer without an error.
    function automatic logic reg_mapped(input logic [AW-1:0] a);
        logic [11:0] w;
        w = 12'(a);
        reg_mapped = (w == acalu_pkg::ACALU_OFF_INSTR) || (w == acalu_pkg::ACALU_OFF_ACC)
            || (w == acalu_pkg::ACALU_OFF_STATUS) || (w == acalu_pkg::ACALU_OFF_FADDR)
            || (w == acalu_pkg::ACALU_OFF_FDATA) || (w == acalu_pkg::ACALU_OFF_CFG)
            || (w == acalu_pkg::ACALU_OFF_CYCLES);
    endfunction

    function automatic logic reg_hit(input logic [AW-1:0] a, input logic [11:0] off);
        reg_hit = (12'(a) == off);
    endfunction

    logic [7:0] acc_q;
    logic c_q;
    logic digit_carry_q;
    logic z_q;
    logic skip_q;
    logic skip_d;
    logic cfg_q;
    logic [6:0] faddr_q;
    logic [23:0] instr_q;
    logic [CYC_W-1:0] cycles_q;
    logic [7:0] port_out_q;
    logic presc_clr_q;
    logic [31:0] prdata_q;
    logic [7:0] pins_meta_q;
    logic [7:0] pins_q;

    logic access;
    logic wr_access;
    logic setup;
    logic issue;
    logic discard;
    logic exec;
    acalu_pkg::acalu_op_t op;
    logic dest;
    logic [2:0] bit_idx;
    logic [6:0] fa;
    logic [7:0] lit;
    logic [6:0] rd_addr;
    logic [7:0] rd_raw;
    logic [7:0] rd_val;
    logic [7:0] operand;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_digit_carry;
    logic alu_z;
    logic bit_val;
    logic is_add;
    logic is_and;
    logic is_lit;
    logic wr_acc;
    logic wr_file;
    logic apb_file_wr;
    logic fwr_en;
    logic [6:0] fwr_addr;
    logic [7:0] fwr_data;
    logic skip_set;
    logic status_wr;

    // APB decode: pready is tied high, so every access phase completes in one cycle.
    assign access = psel && penable;
    assign wr_access = access && pwrite;
    assign setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = access && !reg_mapped(paddr);

    assign issue = wr_access && reg_hit(paddr, acalu_pkg::ACALU_OFF_INSTR);
    assign discard = skip_q;
    assign exec = issue && !discard;

    assign op = acalu_pkg::acalu_op_t'(pwdata[acalu_pkg::ACALU_OP_LSB +: 4]);
    assign dest = pwdata[acalu_pkg::ACALU_DEST_POS];
    assign bit_idx = pwdata[acalu_pkg::ACALU_BIT_LSB +: 3];
    assign fa = pwdata[acalu_pkg::ACALU_FA_LSB +: 7];
    assign lit = pwdata[acalu_pkg::ACALU_LIT_LSB +: 8];

    // Pins pass two flip-flops before any logic sees them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_meta_q <= 8'h00;
            pins_q <= 8'h00;
        end else begin
            pins_meta_q <= port_pins;
            pins_q <= pins_meta_q;
        end
    end

    assign rd_addr = issue ? fa : faddr_q;

    // The file registers are also reachable by software through the address and data registers.
    acalu_file_regs #(
        .AW(7),
        .DW(8)
    ) u_file (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(fwr_en),
        .wr_addr(fwr_addr),
        .wr_data(fwr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_raw)
    );

    // A read-modify-write of the port sees the pins, not the output latch.
    assign rd_val = (rd_addr == PORT_ADDR) ? pins_q : rd_raw;

    assign is_lit = (op == acalu_pkg::ACALU_ADD_LITERAL_TO_ACC) || (op == acalu_pkg::ACALU_AND_LITERAL_WITH_ACC);
    assign is_add = (op == acalu_pkg::ACALU_ADD_LITERAL_TO_ACC) || (op == acalu_pkg::ACALU_ADD_ACC_AND_REG);
    assign is_and = (op == acalu_pkg::ACALU_AND_LITERAL_WITH_ACC) || (op == acalu_pkg::ACALU_AND_ACC_WITH_REG);
    assign operand = is_lit ? lit : rd_val;

    acalu_alu u_alu (
        .op(op),
        .acc(acc_q),
        .operand(operand),
        .bit_idx(bit_idx),
        .result(alu_res),
        .carry(alu_c),
        .digit_carry(alu_digit_carry),
        .zero(alu_z),
        .bit_val(bit_val)
    );

    // Destination steering of each operation.
    always_comb begin
        wr_acc = 1'b0;
        wr_file = 1'b0;
        unique case (op)
            acalu_pkg::ACALU_ADD_LITERAL_TO_ACC: wr_acc = exec;
            acalu_pkg::ACALU_AND_LITERAL_WITH_ACC: wr_acc = exec;
            acalu_pkg::ACALU_ADD_ACC_AND_REG,
            acalu_pkg::ACALU_AND_ACC_WITH_REG: begin
                wr_acc = exec && !dest;
                wr_file = exec && dest;
            end
            acalu_pkg::ACALU_BIT_CLEAR_OP,
            acalu_pkg::ACALU_BIT_SET_OP,
            acalu_pkg::ACALU_REGISTER_CLEAR_OP: wr_file = exec;
            default: begin
                wr_acc = 1'b0;
                wr_file = 1'b0;
            end
        endcase
    end

    assign apb_file_wr = wr_access && reg_hit(paddr, acalu_pkg::ACALU_OFF_FDATA);
    assign status_wr = wr_access && reg_hit(paddr, acalu_pkg::ACALU_OFF_STATUS);
    assign fwr_en = wr_file || apb_file_wr;
    assign fwr_addr = wr_file ? fa : faddr_q;
    assign fwr_data = wr_file ? alu_res : pwdata[7:0];

    // Accumulator: instruction results, else direct software write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= acalu_pkg::ACALU_ACC_RST;
        end else if (wr_acc) begin
            acc_q <= alu_res;
        end else if (wr_access && reg_hit(paddr, acalu_pkg::ACALU_OFF_ACC)) begin
            acc_q <= pwdata[7:0];
        end
    end

    // Carry moves only on additions and on software writes of the status word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= acalu_pkg::ACALU_FLAGS_RST[acalu_pkg::ACALU_ST_C];
        end else if (exec && is_add) begin
            c_q <= alu_c;
        end else if (status_wr) begin
            c_q <= pwdata[acalu_pkg::ACALU_ST_C];
        end
    end

    // Digit carry follows the same pattern as carry, from the carry out of bit 3 of the sum.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digit_carry_q <= acalu_pkg::ACALU_FLAGS_RST[acalu_pkg::ACALU_ST_DIGIT_CARRY];
        end else if (exec && is_add) begin
            digit_carry_q <= alu_digit_carry;
        end else if (status_wr) begin
            digit_carry_q <= pwdata[acalu_pkg::ACALU_ST_DIGIT_CARRY];
        end
    end

    // Zero follows additions and AND, register clear forces it, bit operations leave it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_q <= acalu_pkg::ACALU_FLAGS_RST[acalu_pkg::ACALU_ST_Z];
        end else if (exec && is_add) begin
            z_q <= alu_z;
        end else if (exec && is_and) begin
            z_q <= alu_z;
        end else if (exec && op == acalu_pkg::ACALU_REGISTER_CLEAR_OP) begin
            z_q <= 1'b1;
        end else if (status_wr) begin
            z_q <= pwdata[acalu_pkg::ACALU_ST_Z];
        end
    end

    // Skip tests only arm the discard of the next instruction.
    assign skip_set = exec && (((op == acalu_pkg::ACALU_SKIP_IF_BIT_SET) && bit_val)
        || ((op == acalu_pkg::ACALU_SKIP_IF_BIT_CLEAR) && !bit_val));

    // The next issued instruction is executed as a no-operation and consumes the pending skip.
    assign skip_d = skip_set || (skip_q && !issue);

    // Pending discard of the next issued instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    // Every issued instruction, discarded or not, is one instruction cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycles_q <= '0;
        end else if (issue) begin
            cycles_q <= cycles_q + CYC_W'(1);
        end
    end

    // Last issued instruction word, kept for read-back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= 24'h00_0000;
        end else if (issue) begin
            instr_q <= pwdata[23:0];
        end
    end

    // File address used by software data accesses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr_q <= 7'h00;
        end else if (wr_access && reg_hit(paddr, acalu_pkg::ACALU_OFF_FADDR)) begin
            faddr_q <= pwdata[6:0];
        end
    end

    // Set while the prescaler is assigned to timer zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= acalu_pkg::ACALU_CFG_RST;
        end else if (wr_access && reg_hit(paddr, acalu_pkg::ACALU_OFF_CFG)) begin
            cfg_q <= pwdata[0];
        end
    end

    // Output latch of the port follows every write to the port address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_out_q <= acalu_pkg::ACALU_FILE_RST;
        end else if (fwr_en && fwr_addr == PORT_ADDR) begin
            port_out_q <= fwr_data;
        end
    end

    // One-cycle pulse when an instruction writes timer zero while it owns the prescaler.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_clr_q <= 1'b0;
        end else begin
            presc_clr_q <= wr_file && (fa == TIMER_ZERO_ADDR) && cfg_q;
        end
    end

    // Read data is captured in the setup cycle so it is stable through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= 32'h0000_0000;
            unique case (12'(paddr))
                acalu_pkg::ACALU_OFF_INSTR: prdata_q <= {8'h00, instr_q};
                acalu_pkg::ACALU_OFF_ACC: prdata_q <= {24'h00_0000, acc_q};
                acalu_pkg::ACALU_OFF_STATUS: prdata_q <= {28'h000_0000, skip_q, z_q, digit_carry_q, c_q};
                acalu_pkg::ACALU_OFF_FADDR: prdata_q <= {25'h000_0000, faddr_q};
                acalu_pkg::ACALU_OFF_FDATA: prdata_q <= {24'h00_0000, rd_val};
                acalu_pkg::ACALU_OFF_CFG: prdata_q <= {31'h0000_0000, cfg_q};
                acalu_pkg::ACALU_OFF_CYCLES: prdata_q <= 32'(cycles_q);
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign port_latch = port_out_q;
    assign acc = acc_q;
    assign flag_c = c_q;
    assign digit_carry_flag = digit_carry_q;
    assign flag_z = z_q;
    assign skip_next = skip_q;
    assign prescaler_clear = presc_clr_q;
endmodule

// *** sim/acalu_top_properties.sv ***
// Concurrent checks on the ports of the accumulator ALU top.
// Assumes it is bound to acalu_top and sees only that module's ports.
`timescale 1ns/1ps
module acalu_top_properties #(
    parameter int unsigned AW = 12,
    parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] acc,
    input wire logic flag_c,
    input wire logic digit_carry_flag,
    input wire logic flag_z,
    input wire logic skip_next,
    input wire logic prescaler_clear
);
    logic ins_wr;
    logic run_wr;
    logic tst_wr;
    logic tz_wr;
    logic [3:0] op;
    logic [7:0] lit;
    logic [8:0] lsum;
    logic [4:0] nsum;
    logic sum_c;
    logic sum_digit_carry;
    logic [7:0] sum_lo;
    assign ins_wr = psel && penable && pwrite && (paddr == '0);
    assign run_wr = ins_wr && !skip_next;
    assign op = pwdata[3:0];
    assign lit = pwdata[23:16];
    assign tst_wr = ins_wr && (op == 4'h7 || op == 4'h8);
    assign tz_wr = run_wr && (pwdata[14:8] == TIMER_ZERO_ADDR);
    assign lsum = {1'b0, acc} + {1'b0, lit};
    assign nsum = {1'b0, acc[3:0]} + {1'b0, lit[3:0]};
    assign sum_c = lsum[8];
    assign sum_digit_carry = nsum[4];
    assign sum_lo = lsum[7:0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence run_s(logic [3:0] o);
        run_wr && op == o;
    endsequence
    sequence flags_kept_s;
        $stable(flag_c) && $stable(digit_carry_flag) && $stable(flag_z);
    endsequence

    add_lit_sum_a: assert property (run_s(4'h1) |=> acc == $past(sum_lo) && flag_z == (acc == 8'h00))
        else $error("add literal result wrong");
    add_carries_a: assert property (
        run_s(4'h1) |=> flag_c == $past(sum_c) && digit_carry_flag == $past(sum_digit_carry))
        else $error("add literal carries wrong");
    and_lit_res_a: assert property (run_s(4'h4) |=> acc == ($past(acc) & $past(lit)) && $stable(flag_c))
        else $error("and literal result wrong");
    and_reg_flags_a: assert property (run_s(4'h3) |=> $stable(flag_c) && $stable(digit_carry_flag))
        else $error("and register touched carries");
    file_dest_a: assert property (run_wr && pwdata[4] && (op == 4'h2 || op == 4'h3) |=> $stable(acc))
        else $error("file destination changed accumulator");
    bit_ops_kept_a: assert property (
        run_wr && op >= 4'h5 && op <= 4'h8 |=> flags_kept_s ##0 $stable(acc))
        else $error("bit operation changed flags or accumulator");
    clear_sets_z_a: assert property (run_s(4'h9) |=> flag_z && $stable(acc))
        else $error("register clear did not set zero flag");
    skip_discard_a: assert property (
        ins_wr && skip_next |=> (!skip_next && $stable(acc)) ##0 flags_kept_s)
        else $error("discarded instruction had an effect");
    skip_source_a: assert property ($rose(skip_next) |-> $past(tst_wr))
        else $error("skip raised without a bit test");
    prescaler_pulse_a: assert property (prescaler_clear |-> $past(tz_wr) ##1 !prescaler_clear)
        else $error("prescaler clear pulse wrong");
endmodule

bind acalu_top acalu_top_properties #(.AW(AW), .TIMER_ZERO_ADDR(TIMER_ZERO_ADDR)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .acc(acc), .flag_c(flag_c), .digit_carry_flag(digit_carry_flag), .flag_z(flag_z),
    .skip_next(skip_next), .prescaler_clear(prescaler_clear)
);

// *** sim/acalu_top_tb_top.sv ***
// Self-checking testbench for the accumulator ALU top, driven over APB.
// Assumes the checker is bound from its own file and zero-wait-state answers are not relied upon.
`timescale 1ns/1ps
module acalu_top_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] port_pins = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] port_latch;
    logic [7:0] acc;
    logic flag_c;
    logic dcf;
    logic flag_z;
    logic skip_next;
    logic prescaler_clear;
    int err_count = 0;
    int check_count = 0;
    int n_ins = 0;
    logic pc_seen = 1'b0;
    logic [31:0] rd;
    logic er;
    logic [3:0] sop [4] = '{4'h7, 4'h7, 4'h8, 4'h8};
    logic [2:0] sb [4] = '{3'h3, 3'h0, 3'h4, 3'h3};
    logic sk [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #4 pclk = ~pclk;
    always @(posedge pclk) if (prescaler_clear === 1'b1) pc_seen <= 1'b1;

    acalu_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pins(port_pins),
        .port_latch(port_latch), .acc(acc), .flag_c(flag_c), .digit_carry_flag(dcf), .flag_z(flag_z),
        .skip_next(skip_next), .prescaler_clear(prescaler_clear)
    );

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error flag land in rd and er.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            results();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (w && a == 12'h000) n_ins++;
        end
    endtask

    function automatic logic [31:0] ins(input logic [3:0] op, input logic d, input logic [2:0] b,
                                        input logic [6:0] fa, input logic [7:0] k);
        return {8'h00, k, 1'b0, fa, b, d, op};
    endfunction

    // Loads accumulator, file register and flags, issues one instruction and reads all three back.
    task automatic run(input logic [31:0] i, input logic [7:0] a, input logic [7:0] f, input logic [3:0] s,
                       input logic [7:0] ea, input logic [7:0] ef, input logic [3:0] es);
        apb(1'b1, 12'h00C, 32'(i[14:8]));
        apb(1'b1, 12'h010, 32'(f));
        apb(1'b1, 12'h004, 32'(a));
        apb(1'b1, 12'h008, 32'(s));
        apb(1'b1, 12'h000, i);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'(ea));
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'(ef));
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd, 32'(es));
        chk(32'(acc), 32'(ea));
        chk({28'h000_0000, skip_next, flag_z, dcf, flag_c}, 32'(es));
    endtask

    initial begin
        #100000;
        err_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        run(ins(4'h1, 1'b0, 3'h0, 7'h20, 8'h01), 8'h0F, 8'h00, 4'h0, 8'h10, 8'h00, 4'h2);
        run(ins(4'h1, 1'b0, 3'h0, 7'h20, 8'h01), 8'hFF, 8'h00, 4'h0, 8'h00, 8'h00, 4'h7);
        run(ins(4'h2, 1'b0, 3'h0, 7'h7F, 8'h00), 8'h80, 8'h80, 4'h0, 8'h00, 8'h80, 4'h5);
        run(ins(4'h2, 1'b1, 3'h0, 7'h20, 8'h00), 8'h19, 8'h28, 4'h0, 8'h19, 8'h41, 4'h2);
        run(ins(4'h3, 1'b0, 3'h0, 7'h20, 8'h00), 8'hF0, 8'h0F, 4'h3, 8'h00, 8'h0F, 4'h7);
        run(ins(4'h3, 1'b1, 3'h0, 7'h20, 8'h00), 8'hAA, 8'hFF, 4'h7, 8'hAA, 8'hAA, 4'h3);
        run(ins(4'h4, 1'b0, 3'h0, 7'h20, 8'hC3), 8'h3C, 8'h11, 4'h3, 8'h00, 8'h11, 4'h7);
        run(ins(4'h5, 1'b0, 3'h7, 7'h20, 8'h00), 8'h01, 8'hFF, 4'h5, 8'h01, 8'h7F, 4'h5);
        run(ins(4'h6, 1'b0, 3'h0, 7'h20, 8'h00), 8'h01, 8'h00, 4'h2, 8'h01, 8'h01, 4'h2);
        run(ins(4'h9, 1'b1, 3'h0, 7'h20, 8'h00), 8'h01, 8'h5A, 4'h0, 8'h01, 8'h00, 4'h4);
        for (int i = 0; i < 4; i++) begin
            run(ins(sop[i], 1'b0, sb[i], 7'h20, 8'h00), 8'h33, 8'h08, 4'h5, 8'h33, 8'h08, {sk[i], 3'h5});
            run(32'h0001_2001, 8'h10, 8'h08, 4'h0, sk[i] ? 8'h10 : 8'h11, 8'h08, 4'h0);
        end
        port_pins <= 8'h5A;
        apb(1'b1, 12'h00C, 32'h0000_0006);
        apb(1'b1, 12'h010, 32'h0000_0000);
        apb(1'b1, 12'h000, ins(4'h6, 1'b0, 3'h0, 7'h06, 8'h00));
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h0000_005A);
        chk(32'(port_latch), 32'h0000_005B);
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, 12'h014, 32'(c));
            apb(1'b1, 12'h00C, 32'h0000_0001);
            pc_seen = 1'b0;
            apb(1'b1, 12'h010, 32'h0000_0055);
            apb(1'b1, 12'h000, ins(4'h9, 1'b1, 3'h0, 7'h01, 8'h00));
            apb(1'b0, 12'h00C, 32'h0000_0000);
            chk(32'(pc_seen), 32'(c));
        end
        apb(1'b0, 12'h01C, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        apb(1'b0, 12'h018, 32'h0000_0000);
        chk(rd, 32'(n_ins));
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        results();
    end
endmodule
